// ### design/mbag_addr_gen.sv
// What this block does
// RULE1: modulo correction on any working register
// RULE2: magnitude compare against upper or lower bound
// RULE3: write back only for pre/post modify
// RULE4: offset form corrects address, pointer untouched
// RULE5: reversal only in x generator, writes
// RULE6: only the modifier is bit reversed
// RULE7: reversal needs select not 1111, enable, inc
// RULE8: software aligns reversed buffer to its size
// RULE9: pivot modifier is a 15-bit field
// RULE10: reversed accesses are words, lsb zero
// RULE11: bytes and other modes stay normal
// RULE12: pointer plus pivot, mode offset ignored
// RULE13: reversal beats modulo on writes
// RULE14: software avoids read right after control write
// RULE15: crossing wraps by the buffer length
`timescale 1ns/1ps
module mbag_addr_gen import mbag_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic req_vld,
  input wire logic [3:0] req_wreg,
  input wire mbag_mode_e req_mode,
  input wire logic [15:0] req_ptr,
  input wire logic [15:0] req_offset,
  input wire logic req_write,
  input wire logic req_byte,
  input wire logic req_agu_x,
  input wire logic circ_enable,
  input wire logic [3:0] circ_wreg_sel,
  input wire logic [15:0] circ_start,
  input wire logic [15:0] circ_end,
  input wire logic [3:0] reverse_pointer_select_field,
  input wire logic bit_reverse_enable,
  input wire logic [14:0] reverse_pivot_modifier,
  output logic ea_vld_q,
  output logic [15:0] ea_q,
  output logic wb_en_q,
  output logic [3:0] wb_wreg_q,
  output logic [15:0] wb_data_q,
  output logic brev_used_q,
  output logic circ_wrap_q
);
  logic is_inc, is_dec, is_pre, is_post, is_off;
  logic brev_ok, circ_hit, circ_dir_inc, circ_dir_dec, wrap_raw;
  logic [15:0] step, norm_next, circ_fix, brev_next, new_ptr, pivot_bytes;
  logic ea_vld_d, wb_en_d, brev_used_d, circ_wrap_d;
  logic [15:0] ea_d, wb_data_d;
  logic [3:0] wb_wreg_d;

  // decode of the addressing mode
  always_comb begin
    is_inc = (req_mode == MBAG_PRE_INC) || (req_mode == MBAG_POST_INC);
    is_dec = (req_mode == MBAG_PRE_DEC) || (req_mode == MBAG_POST_DEC);
    is_pre = (req_mode == MBAG_PRE_INC) || (req_mode == MBAG_PRE_DEC);
    is_post = (req_mode == MBAG_POST_INC) || (req_mode == MBAG_POST_DEC);
    is_off = (req_mode == MBAG_REG_OFFSET);
  end

  // reversal qualifier: x side, word write, pre/post increment only
  assign brev_ok = req_agu_x && req_write && !req_byte // RULE5 RULE11
    && bit_reverse_enable && (reverse_pointer_select_field != MBAG_WSEL_STACK) // RULE7
    && (req_wreg == reverse_pointer_select_field) && is_inc; // RULE7

  // any register may be the circular pointer, stack select included
  assign circ_hit = circ_enable && (req_wreg == circ_wreg_sel); // RULE1
  assign circ_dir_inc = is_inc || (is_off && !req_offset[MBAG_SIGN_BIT]);
  assign circ_dir_dec = is_dec || (is_off && req_offset[MBAG_SIGN_BIT]);

  // normal pointer arithmetic
  always_comb begin
    step = req_byte ? MBAG_STEP_BYTE : MBAG_STEP_WORD;
    norm_next = req_ptr;
    if (is_inc) begin
      norm_next = req_ptr + step;
    end else if (is_dec) begin
      norm_next = req_ptr - step;
    end else if (is_off) begin
      norm_next = req_ptr + req_offset;
    end
  end

  mbag_modulo u_circ (
    .addr_raw(norm_next),
    .is_inc(circ_dir_inc && circ_hit),
    .is_dec(circ_dir_dec && circ_hit),
    .buf_start(circ_start),
    .buf_end(circ_end),
    .addr_fix(circ_fix),
    .wrapped(wrap_raw)
  );

  // pivot scaled to bytes; the pointer itself keeps normal order
  assign pivot_bytes = {reverse_pivot_modifier, 1'b0}; // RULE9 RULE10
  // only the modifier walks in reversed bit order; step is ignored
  assign brev_next = mbag_rev_add(req_ptr, pivot_bytes) & MBAG_WORD_MASK; // RULE6 RULE12

  // reversal overrides modulo when both claim the pointer
  assign new_ptr = brev_ok ? brev_next : circ_fix; // RULE13

  // next values of the answer stage
  always_comb begin
    ea_vld_d = req_vld;
    ea_d = ea_q;
    wb_en_d = 1'b0;
    wb_wreg_d = wb_wreg_q;
    wb_data_d = wb_data_q;
    brev_used_d = 1'b0;
    circ_wrap_d = 1'b0;
    if (req_vld) begin
      if (is_pre || is_off) begin
        ea_d = new_ptr; // RULE4
      end else begin
        ea_d = req_ptr;
      end
      if (brev_ok) begin
        ea_d = ea_d & MBAG_WORD_MASK; // RULE10
      end
      // offset form never disturbs the register
      wb_en_d = is_pre || is_post; // RULE3 RULE4
      wb_wreg_d = req_wreg;
      wb_data_d = new_ptr; // RULE3
      brev_used_d = brev_ok;
      circ_wrap_d = wrap_raw && !brev_ok;
    end
  end

  // one registered stage; outputs stay quiet after reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ea_vld_q <= 1'b0;
      ea_q <= MBAG_ADDR_RST;
      wb_en_q <= 1'b0;
      wb_wreg_q <= '0;
      wb_data_q <= MBAG_ADDR_RST;
      brev_used_q <= 1'b0;
      circ_wrap_q <= 1'b0;
    end else begin
      ea_vld_q <= ea_vld_d;
      ea_q <= ea_d;
      wb_en_q <= wb_en_d;
      wb_wreg_q <= wb_wreg_d;
      wb_data_q <= wb_data_d;
      brev_used_q <= brev_used_d;
      circ_wrap_q <= circ_wrap_d;
    end
  end

  // checks on the answer stage
  a_wb_only_modify: assert property (@(posedge core_clk) disable iff (!rstn) // RULE3
    wb_en_q |-> $past(req_vld) && ($past(is_pre) || $past(is_post)))
    else $error("pointer written back without pre or post modify");
  a_offset_no_wb: assert property (@(posedge core_clk) disable iff (!rstn) // RULE4
    $past(req_vld && is_off) |-> !wb_en_q && ea_vld_q)
    else $error("offset form changed the pointer");
  a_brev_x_write: assert property (@(posedge core_clk) disable iff (!rstn) // RULE5
    brev_used_q |-> $past(req_agu_x) && $past(req_write))
    else $error("reversal outside x generator writes");
  a_brev_enable_cond: assert property (@(posedge core_clk) disable iff (!rstn) // RULE7
    brev_used_q |-> $past(bit_reverse_enable) && $past(is_inc)
      && $past(reverse_pointer_select_field) != MBAG_WSEL_STACK)
    else $error("reversal without all enabling conditions");
  a_brev_lsb_zero: assert property (@(posedge core_clk) disable iff (!rstn) // RULE10
    brev_used_q |-> !ea_q[0] && !wb_data_q[0])
    else $error("reversed address has lsb set");
  a_byte_normal: assert property (@(posedge core_clk) disable iff (!rstn) // RULE11
    $past(req_vld && req_byte) |-> !brev_used_q)
    else $error("byte access took reversed address");
  a_brev_value: assert property (@(posedge core_clk) disable iff (!rstn) // RULE6
    brev_used_q |-> wb_data_q == (mbag_rev_add($past(req_ptr),
      {$past(reverse_pivot_modifier), 1'b0}) & MBAG_WORD_MASK))
    else $error("reversed pointer value wrong");
  a_brev_over_circ: assert property (@(posedge core_clk) disable iff (!rstn) // RULE13
    brev_used_q |-> !circ_wrap_q)
    else $error("modulo applied over reversal");
  a_wrap_in_range: assert property (@(posedge core_clk) disable iff (!rstn) // RULE15
    circ_wrap_q && $past(circ_start) <= $past(circ_end) && $past(circ_dir_inc)
      && $past(norm_next) <= $past(circ_end) + ($past(circ_end) - $past(circ_start))
      |-> wb_data_q >= $past(circ_start) && wb_data_q <= $past(circ_end))
    else $error("wrapped address left the buffer");
  a_vld_follows: assert property (@(posedge core_clk) disable iff (!rstn)
    req_vld |=> ea_vld_q ##1 (ea_vld_q == $past(req_vld)))
    else $error("answer valid not one cycle after request");

  // wrap direction and amount; an equality compare would miss jumps past the edge
  a_wrap_upper: assert property (@(posedge core_clk) disable iff (!rstn) // RULE2
    circ_wrap_q && $past(is_inc) |-> $past(norm_next) > $past(circ_end))
    else $error("upward wrap without passing the upper bound");
  a_wrap_lower: assert property (@(posedge core_clk) disable iff (!rstn) // RULE2
    circ_wrap_q && $past(is_dec) |-> $past(norm_next) < $past(circ_start))
    else $error("downward wrap without passing the lower bound");
  a_wrap_fold: assert property (@(posedge core_clk) disable iff (!rstn) // RULE15
    circ_wrap_q && $past(circ_dir_inc) |-> wb_data_q
      == $past(norm_next) - ($past(circ_end) - $past(circ_start) + MBAG_STEP_BYTE))
    else $error("upward wrap not folded by the buffer length");
  a_circ_selected: assert property (@(posedge core_clk) disable iff (!rstn) // RULE1
    circ_wrap_q |-> $past(circ_enable) && $past(req_wreg) == $past(circ_wreg_sel))
    else $error("modulo applied to an unselected register");
  a_circ_off_quiet: assert property (@(posedge core_clk) disable iff (!rstn) // RULE1
    $past(req_vld) && !$past(circ_enable) |-> !circ_wrap_q)
    else $error("modulo applied while disabled");
  a_pre_ea_wb: assert property (@(posedge core_clk) disable iff (!rstn) // RULE3
    wb_en_q && $past(is_pre) |-> ea_q == wb_data_q)
    else $error("pre modify address differs from written pointer");
  a_idle_quiet: assert property (@(posedge core_clk) disable iff (!rstn) // RULE3
    !$past(req_vld) |-> !wb_en_q && !brev_used_q && !circ_wrap_q)
    else $error("status or write back without a request");
  a_brev_post_ea: assert property (@(posedge core_clk) disable iff (!rstn) // RULE10
    brev_used_q && $past(is_post) |-> ea_q == ($past(req_ptr) & MBAG_WORD_MASK))
    else $error("reversed post modify address not word aligned pointer");
  a_byte_step: assert property (@(posedge core_clk) disable iff (!rstn) // RULE11
    wb_en_q && !circ_wrap_q && $past(req_byte) && $past(is_inc)
      |-> wb_data_q == $past(req_ptr) + MBAG_STEP_BYTE)
    else $error("byte increment not a normal step");
  a_word_dec_step: assert property (@(posedge core_clk) disable iff (!rstn) // RULE11
    wb_en_q && !circ_wrap_q && !$past(req_byte) && $past(is_dec)
      |-> wb_data_q == $past(req_ptr) - MBAG_STEP_WORD)
    else $error("word decrement not a normal step");

  c_brev_write: cover property (@(posedge core_clk) disable iff (!rstn) brev_used_q);
  c_wrap: cover property (@(posedge core_clk) disable iff (!rstn) circ_wrap_q && wb_en_q);
  c_offset_wrap: cover property (@(posedge core_clk) disable iff (!rstn)
    circ_wrap_q && !wb_en_q);
  c_back_to_back: cover property (@(posedge core_clk) disable iff (!rstn)
    ea_vld_q ##1 ea_vld_q);
  c_wrap_down: cover property (@(posedge core_clk) disable iff (!rstn)
    circ_wrap_q && $past(is_dec));
endmodule

// ### design/mbag_modulo.sv
`timescale 1ns/1ps
package mbag_pkg;
  localparam int MBAG_ADDR_W = 16;
  localparam int MBAG_PIVOT_W = 15;
  localparam int MBAG_WSEL_W = 4;
  // select code that names the stack pointer, never usable for reversal
  localparam logic [3:0] MBAG_WSEL_STACK = 4'hf;
  localparam logic [15:0] MBAG_STEP_BYTE = 16'h0001;
  localparam logic [15:0] MBAG_STEP_WORD = 16'h0002;
  localparam logic [15:0] MBAG_WORD_MASK = 16'hfffe;
  localparam logic [15:0] MBAG_ADDR_RST = 16'h0000;
  localparam int MBAG_SIGN_BIT = 15;

  typedef enum logic [2:0] {
    MBAG_INDIRECT = 3'b000,
    MBAG_POST_DEC = 3'b001,
    MBAG_POST_INC = 3'b010,
    MBAG_PRE_DEC = 3'b011,
    MBAG_PRE_INC = 3'b100,
    MBAG_REG_OFFSET = 3'b101
  } mbag_mode_e;

  // mirror a 16-bit word end for end
  function automatic logic [15:0] mbag_rev16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < MBAG_ADDR_W; i++) begin
      r[i] = v[MBAG_ADDR_W-1-i];
    end
    return r;
  endfunction

  // add with the carry running from msb toward lsb
  function automatic logic [15:0] mbag_rev_add(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] s;
    s = mbag_rev16(a) + mbag_rev16(b);
    return mbag_rev16(s);
  endfunction
endpackage

module mbag_modulo import mbag_pkg::*; (
  input wire logic [15:0] addr_raw,
  input wire logic is_inc,
  input wire logic is_dec,
  input wire logic [15:0] buf_start,
  input wire logic [15:0] buf_end,
  output logic [15:0] addr_fix,
  output logic wrapped
);
  logic [15:0] buf_len;

  // length counts both ends of the buffer
  assign buf_len = buf_end - buf_start + MBAG_STEP_BYTE;

  // magnitude compares, so a jump past the edge still gets folded back
  always_comb begin
    addr_fix = addr_raw;
    wrapped = 1'b0;
    if (is_inc && (addr_raw > buf_end)) begin // RULE2
      addr_fix = addr_raw - buf_len; // RULE15
      wrapped = 1'b1;
    end else if (is_dec && (addr_raw < buf_start)) begin // RULE2
      addr_fix = addr_raw + buf_len; // RULE15
      wrapped = 1'b1;
    end
  end
endmodule

// ### dv/mbag_cpu_model.sv
`timescale 1ns/1ps
module mbag_cpu_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic wb_en_q,
  input wire logic [3:0] wb_wreg_q,
  input wire logic [15:0] wb_data_q,
  input wire logic [3:0] rd_wreg,
  output logic [15:0] rd_ptr
);
  logic [15:0] regs_q [16];

  // pointer file; reset puts register n at n<<12, so the reversed buffer is aligned
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= {i[3:0], 12'h000};
      end
    end else if (wb_en_q) begin
      regs_q[wb_wreg_q] <= wb_data_q;
    end
  end

  // bypass, or a back-to-back request would read a stale pointer
  assign rd_ptr = (wb_en_q && wb_wreg_q == rd_wreg) ? wb_data_q : regs_q[rd_wreg];
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top import mbag_pkg::*;;
  logic core_clk, rstn, req_vld, req_write, req_byte, req_agu_x, circ_enable;
  logic bit_reverse_enable, ea_vld_q, wb_en_q, brev_used_q, circ_wrap_q;
  logic [3:0] req_wreg, circ_wreg_sel, reverse_pointer_select_field, wb_wreg_q;
  logic [15:0] req_ptr, req_offset, circ_start, circ_end, ea_q, wb_data_q, e, w;
  logic [14:0] reverse_pivot_modifier;
  mbag_mode_e req_mode;
  logic [15:0] mptr [16];
  logic [25:0] tbl [4];
  logic we, br, wr, pend;
  logic [31:0] r;
  int fail_count = 0;
  int num_checks = 0;

  mbag_addr_gen i_dut (.core_clk, .rstn, .req_vld, .req_wreg, .req_mode, .req_ptr,
    .req_offset, .req_write, .req_byte, .req_agu_x, .circ_enable, .circ_wreg_sel,
    .circ_start, .circ_end, .reverse_pointer_select_field, .bit_reverse_enable,
    .reverse_pivot_modifier, .ea_vld_q, .ea_q, .wb_en_q, .wb_wreg_q, .wb_data_q,
    .brev_used_q, .circ_wrap_q);
  mbag_cpu_model i_cpu (.core_clk, .rstn, .wb_en_q, .wb_wreg_q, .wb_data_q,
    .rd_wreg(req_wreg), .rd_ptr(req_ptr));

  // clock, 40 ns period
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // add with the carry moving from msb down to lsb
  function automatic logic [15:0] radd(input logic [15:0] a, input logic [15:0] b);
    logic c;
    logic [15:0] s;
    c = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      s[i] = a[i] ^ b[i] ^ c;
      c = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
    end
    return s;
  endfunction

  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (!ok) begin
      fail_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic end_sim();
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // reference answer from the current request and the mirrored pointers
  task automatic model();
    logic [15:0] p;
    logic [15:0] st;
    logic [15:0] len;
    logic inc, dec, up;
    p = mptr[req_wreg];
    st = req_byte ? 16'h0001 : 16'h0002;
    inc = req_mode inside {MBAG_POST_INC, MBAG_PRE_INC};
    dec = req_mode inside {MBAG_POST_DEC, MBAG_PRE_DEC};
    up = inc || (req_mode == MBAG_REG_OFFSET && !req_offset[15]);
    w = inc ? p + st : dec ? p - st : req_mode == MBAG_REG_OFFSET ? p + req_offset : p;
    wr = 1'b0;
    if (circ_enable && req_wreg == circ_wreg_sel && req_mode != MBAG_INDIRECT) begin
      len = circ_end - circ_start + 16'h0001;
      wr = up ? w > circ_end : w < circ_start;
      if (wr) w = up ? w - len : w + len;
    end
    br = req_agu_x && req_write && !req_byte && inc && bit_reverse_enable
      && req_wreg == reverse_pointer_select_field
      && reverse_pointer_select_field != 4'hf;
    if (br) w = radd(p, {reverse_pivot_modifier, 1'b0}) & 16'hfffe;
    if (br) wr = 1'b0;
    we = inc || dec;
    e = !(req_mode inside {MBAG_POST_INC, MBAG_POST_DEC}) ? w : br ? p & 16'hfffe : p;
  endtask

  // reset, then four control set-ups of random back-to-back traffic
  initial begin
    rstn = 1'b0;
    {req_vld, req_write, req_byte, req_agu_x, circ_enable, bit_reverse_enable} = '0;
    {req_wreg, circ_wreg_sel, reverse_pointer_select_field} = '0;
    {req_offset, circ_start, circ_end, reverse_pivot_modifier, e, pend} = '0;
    req_mode = MBAG_INDIRECT;
    r = 32'he074;
    tbl = '{{4'h1, 16'h1000, 4'h2, 2'b11}, {4'h2, 16'h2000, 4'h2, 2'b11},
      {4'h1, 16'h1000, 4'hf, 2'b11}, {4'h3, 16'h3000, 4'h2, 2'b00}};
    for (int i = 0; i < 16; i++) mptr[i] = {i[3:0], 12'h000};
    repeat (8) @(posedge core_clk);
    #1 rstn = 1'b1;
    chk({ea_vld_q, ea_q, wb_en_q, wb_wreg_q, wb_data_q, brev_used_q, circ_wrap_q} === '0, "reset");
    for (int ph = 0; ph < 4; ph++) begin
      for (int c = 0; c < 200; c++) begin
        @(posedge core_clk);
        #1;
        chk(req_ptr === mptr[req_wreg], "pointer file");
        if (pend) begin
          chk(ea_vld_q === 1'b1, "answer valid");
          chk(ea_q === e, "address");
          chk(wb_en_q === we, "writeback enable");
          chk(brev_used_q === br, "reversal flag");
          chk(circ_wrap_q === wr, "wrap flag");
          if (we) chk(wb_wreg_q === req_wreg && wb_data_q === w, "writeback");
        end else begin
          chk(ea_vld_q === 1'b0 && wb_en_q === 1'b0 && ea_q === e, "idle");
        end
        r = lfsr(r);
        if (c == 0) begin
          {circ_wreg_sel, circ_start, reverse_pointer_select_field, circ_enable,
            bit_reverse_enable} = tbl[ph];
          circ_end = circ_start + 16'h001f;
          reverse_pivot_modifier = ph[0] ? 15'h0004 : 15'h0008;
        end
        req_vld = r[1:0] != 2'b00 && c != 0;
        req_wreg = {2'b00, r[3:2]};
        req_mode = mbag_mode_e'(r[6:4] > 3'd5 ? 3'd2 : r[6:4]);
        req_offset = {{11{r[11]}}, r[11:7]};
        {req_write, req_byte, req_agu_x} = {r[12], r[13] & r[14], r[15] | r[16]};
        if (req_vld) model();
        if (req_vld && we) mptr[req_wreg] = w;
        pend = req_vld;
      end
    end
    end_sim();
  end
endmodule
